// *** hdl/plss_pkg.sv ***
// plss_pkg: offsets, field positions, reset values and timing counts of the
// per-port link status / slot capabilities register pair.
// assumes a byte-addressed configuration port with 32-bit data.
package plss_pkg;
	localparam int          ADDR_W            = 12;
	localparam logic [11:0] OFS_LINK_STATUS   = 12'h052;
	localparam logic [11:0] OFS_SLOT_CAP      = 12'h054;

	// link status field positions
	localparam int          LS_SPEED_LSB      = 0;
	localparam int          LS_WIDTH_LSB      = 4;
	localparam int          LS_TRAIN_ERROR_FLAG_BIT       = 10;
	localparam int          LS_TRAIN_BIT      = 11;
	localparam int          LS_SCLK_BIT       = 12;
	localparam int          LS_DLA_BIT        = 13;

	// slot capabilities field positions
	localparam int          SC_PRES_LSB       = 0;
	localparam int          SC_PRES_MSB       = 6;
	localparam int          SC_PLV_LSB        = 7;
	localparam int          SC_PLV_MSB        = 14;
	localparam int          SC_PLS_LSB        = 15;
	localparam int          SC_PLS_MSB        = 16;
	localparam int          SC_EIP_BIT        = 17;
	localparam int          SC_NO_CMD_COMPLETE_SUPPORT_BIT       = 18;
	localparam int          SC_PSN_LSB        = 19;
	localparam int          SC_PSN_MSB        = 31;

	// reset values
	localparam logic [3:0]  RST_SPEED         = 4'h1;
	localparam logic [5:0]  RST_WIDTH         = 6'h00;
	localparam logic [6:0]  RST_PRES          = 7'h00;
	localparam logic [7:0]  RST_PLV           = 8'h00;
	localparam logic [1:0]  RST_PLS           = 2'h0;
	localparam logic [12:0] RST_PSN           = 13'h0000;
	localparam logic        NO_CMD_COMPLETE_SUPPORT_VALUE        = 1'b0;

	// cycles after reset release before the synchronised strap is trusted
	localparam logic [1:0]  STRAP_WAIT        = 2'h3;
endpackage : plss_pkg

// *** hdl/plss_sync.sv ***
// plss_sync: two-flop level synchroniser, also used to release the reset.
// assumes the clock is free running; the first stage feeds only the second.
`timescale 1ns/1ps
module plss_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,    // core clock
	input  wire logic         i_arst_n, // asynchronous reset, active low
	input  wire logic [W-1:0] i_d,      // asynchronous level in
	output logic      [W-1:0] o_q       // synchronised level out
);
	logic [W-1:0] stage1;

	// a zero-width synchroniser has nothing to carry
	if (W < 1) begin : g_bad_width
		$error("plss_sync: W must be at least 1");
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stage1 <= '0;
			o_q    <= '0;
		end else begin
			stage1 <= i_d;
			o_q    <= stage1;
		end
	end
endmodule : plss_sync

// *** hdl/plss_regs.sv ***
// plss_regs: link status and slot capabilities registers of one switch port,
// with the slot power limit message trigger.
// assumes status inputs come from same-clock link logic; straps are pins.
//
// Behaviour
// - link speed bits 3:0, read-only current speed, resets to 1
// - link width bits 9:4, read-only negotiated width from hardware
// - training error bit 10 only under older revision, else zero
// - bit 11 reads one while link training runs
// - bit 12 common clock, taken from up or down strap, load may override
// - bit 13 shows data link active, zero unless capability reports it
// - slot fields read zero and ignore writes when slot not implemented
// - slot bits 0..4 loadable presence flags, reset zero
// - slot bit 5 surprise removal, loadable, reset zero
// - slot bit 6 hot-plug capable, loadable, reset zero
// - bits 14:7 writable power limit value, reset zero
// - bits 16:15 writable power limit scale, reset zero
// - power limit message on slot register write or DL_Up entry
// - slot bit 17 interlock present, loadable, reset zero
// - slot bit 18 hardwired zero
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module plss_regs #(
	parameter bit P_OLD_REV = 1'b0 // 1: training error reported as in older base revision
) (
	input  wire logic        i_clk,             // core clock, 100 MHz
	input  wire logic        i_arst_n,          // asynchronous reset, active low
	input  wire logic [11:0] i_addr,            // register byte offset
	input  wire logic [31:0] i_wdata,           // write data
	input  wire logic        i_wr,              // write strobe
	input  wire logic        i_rd,              // read strobe
	output logic      [31:0] o_rdata,           // read data, cycle after i_rd
	input  wire logic        i_load_wr,         // configuration load write strobe
	input  wire logic [11:0] i_load_addr,       // configuration load offset
	input  wire logic [31:0] i_load_data,       // configuration load data
	input  wire logic        i_unlock,          // register unlock mode
	input  wire logic [3:0]  i_link_speed,      // current link speed code
	input  wire logic [5:0]  i_link_width,      // negotiated link width
	input  wire logic        i_train_error,     // link training error
	input  wire logic        i_training,        // link training in progress
	input  wire logic        i_dl_active,       // data link layer in DL_Up
	input  wire logic        i_dll_report_cap,  // link capability: reports DL active
	input  wire logic        i_slot_impl,       // express capability: slot implemented
	input  wire logic        i_upstream,        // this port is the upstream port
	input  wire logic        i_cclk_up_strap,   // common_clk_up_strap pin
	input  wire logic        i_cclk_down_strap, // common_clk_down_strap pin
	output logic             o_spl_msg,         // one-cycle power limit message request
	output logic      [7:0]  o_spl_value,       // message power limit value
	output logic      [1:0]  o_spl_scale        // message power limit scale
);
	typedef struct packed {
		logic [1:0]  strap_cnt;
		logic        strap_done;
		logic [3:0]  speed;
		logic [5:0]  width;
		logic        train_error_flag;
		logic        train;
		logic        dla;
		logic        sclk;
		logic [6:0]  pres;
		logic [7:0]  plv;
		logic [1:0]  pls;
		logic        interlock_present;
		logic [12:0] psn;
		logic        msg;
		logic [7:0]  msg_val;
		logic [1:0]  msg_scl;
		logic [31:0] rdata;
	} plss_state_s;

	plss_state_s s;
	plss_state_s next_s;
	logic        rst_n;
	logic        strap_up;
	logic        strap_down;
	logic        wr_any;
	logic [11:0] waddr;
	logic [31:0] wdat;
	logic        lock_ok;
	logic        wr_slot;

	plss_sync #(.W(1)) u_rst_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      (1'b1),
		.o_q      (rst_n)
	);

	plss_sync #(.W(2)) u_strap_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      ({i_cclk_up_strap, i_cclk_down_strap}),
		.o_q      ({strap_up, strap_down})
	);

	// the slices below assume the package field positions match the stored widths
	if (plss_pkg::SC_PRES_MSB - plss_pkg::SC_PRES_LSB != 6 ||
		plss_pkg::SC_PLV_MSB - plss_pkg::SC_PLV_LSB != 7 ||
		plss_pkg::SC_PLS_MSB - plss_pkg::SC_PLS_LSB != 1 ||
		plss_pkg::SC_PSN_MSB - plss_pkg::SC_PSN_LSB != 12) begin : g_bad_fields
		$error("plss_regs: slot field positions do not match the stored widths");
	end

	// effective slot word; every field but the hardwired bit is masked off without a slot
	function automatic logic [31:0] slot_word(input plss_state_s st, input logic impl);
		logic [31:0] w;
		w = '0;
		if (impl) begin
			w[plss_pkg::SC_PRES_MSB:plss_pkg::SC_PRES_LSB] = st.pres;
			w[plss_pkg::SC_PLV_MSB:plss_pkg::SC_PLV_LSB]   = st.plv;
			w[plss_pkg::SC_PLS_MSB:plss_pkg::SC_PLS_LSB]   = st.pls;
			w[plss_pkg::SC_EIP_BIT]                        = st.interlock_present;
			w[plss_pkg::SC_PSN_MSB:plss_pkg::SC_PSN_LSB]   = st.psn;
		end
		w[plss_pkg::SC_NO_CMD_COMPLETE_SUPPORT_BIT] = plss_pkg::NO_CMD_COMPLETE_SUPPORT_VALUE;
		return w;
	endfunction : slot_word

	function automatic logic [31:0] link_word(input plss_state_s st, input logic dll_cap);
		logic [31:0] w;
		w = '0;
		w[plss_pkg::LS_SPEED_LSB +: 4] = st.speed;
		w[plss_pkg::LS_WIDTH_LSB +: 6] = st.width;
		w[plss_pkg::LS_TRAIN_ERROR_FLAG_BIT]       = st.train_error_flag;
		w[plss_pkg::LS_TRAIN_BIT]      = st.train;
		w[plss_pkg::LS_SCLK_BIT]       = st.sclk;
		w[plss_pkg::LS_DLA_BIT]        = st.dla & dll_cap;
		return w;
	endfunction : link_word

	// a load write and a bus write in the same cycle: the load wins, the bus write is lost
	assign wr_any  = i_load_wr | i_wr;
	assign waddr   = i_load_wr ? i_load_addr : i_addr;
	assign wdat    = i_load_wr ? i_load_data : i_wdata;
	assign lock_ok = i_load_wr | i_unlock;
	assign wr_slot = wr_any && (waddr == plss_pkg::OFS_SLOT_CAP);

	always_comb begin
		next_s       = s;
		next_s.msg   = 1'b0;
		next_s.rdata = '0;
		next_s.speed = i_link_speed;
		next_s.width = i_link_width;
		next_s.train_error_flag  = P_OLD_REV ? i_train_error : 1'b0;
		next_s.train = i_training;
		next_s.dla   = i_dl_active;
		// strap is sampled once, after the synchroniser has settled
		if (s.strap_cnt != plss_pkg::STRAP_WAIT) begin
			next_s.strap_cnt = s.strap_cnt + 2'h1;
		end else if (!s.strap_done) begin
			next_s.strap_done = 1'b1;
			next_s.sclk       = i_upstream ? strap_up : strap_down;
		end
		if (wr_any && (waddr == plss_pkg::OFS_LINK_STATUS) && lock_ok) begin
			next_s.sclk       = wdat[plss_pkg::LS_SCLK_BIT];
			next_s.strap_done = 1'b1;
		end
		if (wr_slot && i_slot_impl) begin
			if (lock_ok) begin
				next_s.pres = wdat[plss_pkg::SC_PRES_MSB:plss_pkg::SC_PRES_LSB];
				next_s.interlock_present  = wdat[plss_pkg::SC_EIP_BIT];
				next_s.psn  = wdat[plss_pkg::SC_PSN_MSB:plss_pkg::SC_PSN_LSB];
			end
			next_s.plv = wdat[plss_pkg::SC_PLV_MSB:plss_pkg::SC_PLV_LSB];
			next_s.pls = wdat[plss_pkg::SC_PLS_MSB:plss_pkg::SC_PLS_LSB];
		end
		// one message covers a write and a DL_Up entry landing together
		if (wr_slot || (i_dl_active && !s.dla)) begin
			next_s.msg     = 1'b1;
			next_s.msg_val = i_slot_impl ? next_s.plv : 8'h00;
			next_s.msg_scl = i_slot_impl ? next_s.pls : 2'h0;
		end
		if (i_rd) begin
			case (i_addr)
				plss_pkg::OFS_LINK_STATUS: next_s.rdata = link_word(s, i_dll_report_cap);
				plss_pkg::OFS_SLOT_CAP:    next_s.rdata = slot_word(s, i_slot_impl);
				default:                   next_s.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			s       <= '0;
			s.speed <= plss_pkg::RST_SPEED;
			s.width <= plss_pkg::RST_WIDTH;
			s.pres  <= plss_pkg::RST_PRES;
			s.plv   <= plss_pkg::RST_PLV;
			s.pls   <= plss_pkg::RST_PLS;
			s.psn   <= plss_pkg::RST_PSN;
		end else begin
			s <= next_s;
		end
	end

	assign o_rdata     = s.rdata;
	assign o_spl_msg   = s.msg;
	assign o_spl_value = s.msg_val;
	assign o_spl_scale = s.msg_scl;

	a_speed_read: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_LINK_STATUS && $past(rst_n) |=> o_rdata[3:0] == $past(i_link_speed, 2))
		else $error("link speed field does not follow the link");
	a_width_read: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_LINK_STATUS && $past(rst_n) |=> o_rdata[9:4] == $past(i_link_width, 2))
		else $error("link width field does not follow the link");
	a_train_error_flag_new_rev: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_LINK_STATUS && !P_OLD_REV |=> !o_rdata[10])
		else $error("training error visible under newer revision");
	a_train_read: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_LINK_STATUS && $past(rst_n) |=> o_rdata[11] == $past(i_training, 2))
		else $error("training bit does not follow link training");
	a_dla_gated: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_LINK_STATUS && !i_dll_report_cap |=> !o_rdata[13])
		else $error("data link active shown without capability");
	a_slot_masked: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_SLOT_CAP && !i_slot_impl |=> o_rdata == 32'h0000_0000)
		else $error("slot capabilities visible without slot");
	a_no_cmd_complete_support_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_SLOT_CAP |=> !o_rdata[18])
		else $error("no command completed bit not zero");
	a_msg_on_write: assert property (@(posedge i_clk) disable iff (!rst_n)
		wr_slot |=> o_spl_msg && o_spl_value == ($past(i_slot_impl) ? $past(wdat[14:7]) : 8'h00))
		else $error("slot write gave no power limit message");
	a_msg_on_dlup: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_dl_active && !s.dla |=> o_spl_msg)
		else $error("DL_Up entry gave no power limit message");
	a_locked_fields: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_wr && !i_load_wr && !i_unlock |=> s.pres == $past(s.pres) && s.psn == $past(s.psn) && s.interlock_present == $past(s.interlock_present))
		else $error("locked field changed by ordinary write");
	a_plv_store: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_wr && !i_load_wr && i_slot_impl && i_addr == plss_pkg::OFS_SLOT_CAP |=> s.plv == $past(i_wdata[14:7]))
		else $error("power limit value not stored");

	// clock configuration bit: load path, one-time strap capture, then frozen
	a_sclk_load: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_load_wr && i_load_addr == plss_pkg::OFS_LINK_STATUS |=> s.sclk == $past(i_load_data[12]))
		else $error("clock configuration bit not taken from load path");

	a_strap_once: assert property (@(posedge i_clk) disable iff (!rst_n)
		s.strap_done && !i_load_wr && !i_unlock |=> $stable(s.sclk))
		else $error("clock configuration bit changed after strap capture");

	a_strap_capture: assert property (@(posedge i_clk) disable iff (!rst_n)
		!s.strap_done && s.strap_cnt == plss_pkg::STRAP_WAIT && !i_load_wr && !i_unlock
		|=> s.sclk == ($past(i_upstream) ? $past(strap_up) : $past(strap_down)))
		else $error("clock configuration bit not taken from the port strap");

	// slot field updates through the load path and the bus write
	a_presence_load: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_load_wr && i_load_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> s.pres[4:0] == $past(i_load_data[4:0]))
		else $error("presence flags not loaded");

	a_surprise_load: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_load_wr && i_load_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> s.pres[5] == $past(i_load_data[5]))
		else $error("surprise removal bit not loaded");

	a_hotplug_load: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_load_wr && i_load_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> s.pres[6] == $past(i_load_data[6]))
		else $error("hot-plug capable bit not loaded");

	a_eip_load: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_load_wr && i_load_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> s.interlock_present == $past(i_load_data[17]))
		else $error("interlock bit not loaded");

	a_psn_load: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_load_wr && i_load_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> s.psn == $past(i_load_data[31:19]))
		else $error("physical slot number not loaded");

	a_pls_store: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_wr && !i_load_wr && i_slot_impl && i_addr == plss_pkg::OFS_SLOT_CAP |=> s.pls == $past(i_wdata[16:15]))
		else $error("power limit scale not stored");

	a_slot_frozen: assert property (@(posedge i_clk) disable iff (!rst_n)
		wr_slot && !i_slot_impl
		|=> $stable(s.pres) && $stable(s.plv) && $stable(s.pls) && $stable(s.interlock_present) && $stable(s.psn))
		else $error("slot field changed without a slot");

	// message pulse and its payload
	a_msg_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
		!wr_slot && !(i_dl_active && !s.dla) |=> !o_spl_msg)
		else $error("power limit message without a cause");

	a_msg_dlup_val: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_dl_active && !s.dla && !wr_slot && i_slot_impl |=> o_spl_value == $past(s.plv) && o_spl_scale == $past(s.pls))
		else $error("link up message does not carry the stored fields");

	a_msg_noslot: assert property (@(posedge i_clk) disable iff (!rst_n)
		wr_slot && !i_slot_impl |=> o_spl_value == 8'h00 && o_spl_scale == 2'h0)
		else $error("message carries power limit fields without a slot");

	// read-back of the status and slot words
	a_dla_read: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_LINK_STATUS && i_dll_report_cap && $past(rst_n)
		|=> o_rdata[13] == $past(i_dl_active, 2))
		else $error("data link active bit does not follow the link");

	a_pres_read: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> o_rdata[6:0] == $past(s.pres))
		else $error("presence flags not read back");

	a_plv_read: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> o_rdata[14:7] == $past(s.plv))
		else $error("power limit value not read back");

	a_pls_read: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_rd && i_addr == plss_pkg::OFS_SLOT_CAP && i_slot_impl |=> o_rdata[16:15] == $past(s.pls))
		else $error("power limit scale not read back");
endmodule : plss_regs

// *** test/plss_regs_tb_top.sv ***
// plss_regs_tb_top: self-checking bench for the link status / slot capabilities pair.
// assumes the bench drives every port itself; straps change only while reset is held.
`timescale 1ns/1ps
module plss_regs_tb_top;
	typedef struct packed {
		logic [3:0]  sp;
		logic [5:0]  wd;
		logic        te;
		logic        tr;
		logic        dl;
		logic        cap;
		logic [31:0] exp;
	} plss_row_s;

	localparam int TIMEOUT = 3000;

	logic        i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_load_wr = 1'b0, i_unlock = 1'b0;
	logic [11:0] i_addr = 12'h000, i_load_addr = 12'h000;
	logic [31:0] i_wdata = 32'h0, i_load_data = 32'h0, o_rdata, d;
	logic [3:0]  i_link_speed = 4'h1;
	logic [5:0]  i_link_width = 6'h00;
	logic        i_train_error = 1'b0, i_training = 1'b0, i_dl_active = 1'b0, i_dll_report_cap = 1'b0;
	logic        i_slot_impl = 1'b1, i_upstream = 1'b1, i_cclk_up_strap = 1'b1, i_cclk_down_strap = 1'b0;
	logic        o_spl_msg;
	logic [7:0]  o_spl_value;
	logic [1:0]  o_spl_scale;
	int          errors = 0, total_checks = 0, cycles = 0;

	// bit 12 is 1 throughout the rows: upstream strap is high
	plss_row_s   rows [4] = '{'{4'h1, 6'h01, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_1011},
		'{4'h2, 6'h10, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_1902},
		'{4'h2, 6'h3F, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_33F2},
		'{4'h1, 6'h08, 1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_1881}};

	plss_regs i_plss_regs (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_load_wr(i_load_wr), .i_load_addr(i_load_addr),
		.i_load_data(i_load_data), .i_unlock(i_unlock), .i_link_speed(i_link_speed),
		.i_link_width(i_link_width), .i_train_error(i_train_error), .i_training(i_training),
		.i_dl_active(i_dl_active), .i_dll_report_cap(i_dll_report_cap), .i_slot_impl(i_slot_impl),
		.i_upstream(i_upstream), .i_cclk_up_strap(i_cclk_up_strap), .i_cclk_down_strap(i_cclk_down_strap),
		.o_spl_msg(o_spl_msg), .o_spl_value(o_spl_value), .o_spl_scale(o_spl_scale));

	always #5 i_clk = ~i_clk;

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT) begin
			errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			results();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_msg(input logic m, input logic [7:0] v, input logic [1:0] s);
		total_checks++;
		if ({o_spl_msg, o_spl_value, o_spl_scale} !== {m, v, s}) begin
			errors++;
			$display("CHECK FAILED at %0t: message %b %h %h", $time, o_spl_msg, o_spl_value, o_spl_scale);
		end
	endtask : chk_msg

	// ld selects the configuration load path instead of the bus
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic ld);
		@(posedge i_clk);
		i_addr      <= a;
		i_wdata     <= v;
		i_load_addr <= a;
		i_load_data <= v;
		i_wr        <= ~ld;
		i_load_wr   <= ld;
		@(posedge i_clk);
		i_wr      <= 1'b0;
		i_load_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		q = o_rdata;
	endtask : rd

	initial begin
		repeat (10) @(posedge i_clk);
		#1;
		chk_word(o_rdata, 32'h0);
		chk_msg(1'b0, 8'h00, 2'h0);
		repeat (10) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (10) @(posedge i_clk);
		foreach (rows[k]) begin
			i_link_speed     <= rows[k].sp;
			i_link_width     <= rows[k].wd;
			i_train_error    <= rows[k].te;
			i_training       <= rows[k].tr;
			i_dl_active      <= rows[k].dl;
			i_dll_report_cap <= rows[k].cap;
			repeat (2) @(posedge i_clk);
			rd(12'h052, d);
			chk_word(d, rows[k].exp);
			@(posedge i_clk);
		end
		$display("test link status rows finished");
		wr(12'h054, 32'hFFFF_FFFF, 1'b0);
		chk_msg(1'b1, 8'hFF, 2'h3);
		rd(12'h054, d);
		chk_word(d, 32'h0001_FF80);
		i_unlock <= 1'b1;
		wr(12'h054, 32'hFFFF_FFFF, 1'b0);
		chk_msg(1'b1, 8'hFF, 2'h3);
		rd(12'h054, d);
		chk_word(d, 32'hFFFB_FFFF);
		wr(12'h054, 32'hAAAA_AAAA, 1'b0);
		chk_msg(1'b1, 8'h55, 2'h1);
		rd(12'h054, d);
		chk_word(d, 32'hAAAA_AAAA);
		i_unlock <= 1'b0;
		$display("test slot writes finished");
		@(posedge i_clk);
		i_dl_active <= 1'b1;
		@(posedge i_clk);
		#1;
		chk_msg(1'b1, 8'h55, 2'h1);
		@(posedge i_clk);
		#1;
		chk_msg(1'b0, 8'h55, 2'h1);
		$display("test link up message finished");
		// board-level slot: physical slot number left at zero
		wr(12'h054, 32'h0002_003F, 1'b1);
		chk_msg(1'b1, 8'h00, 2'h0);
		rd(12'h054, d);
		chk_word(d, 32'h0002_003F);
		// write then read with no gap between the strobes
		wr(12'h054, 32'h0000_2A00, 1'b0);
		chk_msg(1'b1, 8'h54, 2'h0);
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk_word(o_rdata, 32'h0002_2A3F);
		chk_msg(1'b0, 8'h54, 2'h0);
		@(posedge i_clk);
		#1;
		chk_word(o_rdata, 32'h0);
		$display("test load path and back to back finished");
		i_slot_impl <= 1'b0;
		rd(12'h054, d);
		chk_word(d, 32'h0);
		wr(12'h054, 32'hFFFF_FFFF, 1'b0);
		chk_msg(1'b1, 8'h00, 2'h0);
		i_slot_impl <= 1'b1;
		rd(12'h054, d);
		chk_word(d, 32'h0002_2A3F);
		$display("test slot not implemented finished");
		rd(12'h056, d);
		chk_word(d, 32'h0);
		wr(12'h056, 32'hFFFF_FFFF, 1'b0);
		chk_msg(1'b0, 8'h00, 2'h0);
		wr(12'h052, 32'hFFFF_FFFF, 1'b0);
		rd(12'h052, d);
		chk_word(d, 32'h0000_3881);
		wr(12'h052, 32'h0000_0000, 1'b1);
		rd(12'h052, d);
		chk_word(d, 32'h0000_2881);
		$display("test unmapped and read-only finished");
		// downstream port: bit 12 must come from the other strap after this reset
		i_upstream        <= 1'b0;
		i_cclk_up_strap   <= 1'b0;
		i_cclk_down_strap <= 1'b1;
		i_arst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (10) @(posedge i_clk);
		#1;
		chk_msg(1'b0, 8'h00, 2'h0);
		rd(12'h054, d);
		chk_word(d, 32'h0);
		rd(12'h052, d);
		chk_word(d, 32'h0000_3881);
		$display("test second reset finished");
		results();
	end
endmodule : plss_regs_tb_top
